/* src/ipp_defines.svh */
// Constants for the interrupt presentation and priority block
`ifndef IPP_DEFINES_SVH
`define IPP_DEFINES_SVH
// ********************
// Offsets
// ********************
`define IPP_OFF_POLL 4'h0
`define IPP_OFF_ACCEPT 4'h4
`define IPP_OFF_IPI 4'hC
// ********************
// Fields and values
// ********************
`define IPP_PRIO_MSB 31
`define IPP_PRIO_LSB 24
`define IPP_SRC_MSB 23
`define IPP_IMPL_LSB 13
`define IPP_UNIT_LSB 4
`define IPP_PRIO_LEAST 8'hFF
`define IPP_SRC_NONE 24'h000000
`define IPP_SRC_EARLY_POWER_OFF_WARNING 24'h000001
`define IPP_SRC_OWN_IPI 24'h000002
`define IPP_PRIO_RESET 8'hFF
`define IPP_EARLY_POWER_OFF_WARNING_PRIO 8'h00
`define IPP_NUM_SRC 4
`endif

/* src/ipp_pkg.sv */
// Types shared by the interrupt presentation block
package ipp_pkg;
  typedef logic [7:0] ipp_prio_t;
  typedef logic [23:0] ipp_src_t;
  typedef enum logic [1:0] {IPP_K_EARLY_POWER_OFF_WARNING, IPP_K_IPI, IPP_K_GLOBAL, IPP_K_BUC} ipp_kind_e;
endpackage : ipp_pkg

/* src/ipp_prio_pick.sv */
// Picks the most favoured of several candidate requests
`timescale 1ns/1ps
`default_nettype none
module ipp_prio_pick
  import ipp_pkg::*;
#(
  parameter int N = 4
) (
  // Candidates
  input wire logic [N-1:0] cand_valid,
  input wire logic [N*8-1:0] cand_prio,
  // Winner
  output logic best_valid,
  output logic [1:0] best_idx,
  output ipp_prio_t best_prio
);
  // Lower index wins a tie, so the warning beats equal requests
  always_comb begin
    best_valid = 1'b0;
    best_idx = 2'h0;
    best_prio = 8'hFF;
    for (int i = N - 1; i >= 0; i--) begin
      if (cand_valid[i] && (!best_valid || cand_prio[i*8 +: 8] <= best_prio)) begin
        best_valid = 1'b1;
        best_idx = 2'(i);
        best_prio = cand_prio[i*8 +: 8];
      end
    end
  end
endmodule : ipp_prio_pick
`default_nettype wire

/* src/ipp_present.sv */
// Per-processor interrupt presentation layer with priority filter
`timescale 1ns/1ps
`default_nettype none
`include "ipp_defines.svh"
module ipp_present
  import ipp_pkg::*;
#(
  parameter logic [7:0] EARLY_POWER_OFF_WARNING_PRIO = `IPP_EARLY_POWER_OFF_WARNING_PRIO
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Processor load and store port
  input wire logic cpu_req,
  input wire logic cpu_write,
  input wire logic cpu_gsel,
  input wire logic cpu_size4,
  input wire logic [3:0] cpu_addr,
  input wire logic [31:0] cpu_wdata,
  output logic [31:0] cpu_rdata,
  output logic cpu_ack,
  output logic cpu_irq,
  // Bus unit controller request, asynchronous
  input wire logic buc_req,
  input wire logic [7:0] buc_prio,
  input wire logic [10:0] buc_impl,
  input wire logic [8:0] buc_unit,
  input wire logic [3:0] buc_num,
  // Power warning request, asynchronous
  input wire logic early_power_off_warning_req,
  // Notifications to sources
  output logic buc_taken,
  output logic buc_reject,
  output logic eoi_valid,
  output logic [23:0] eoi_source
);
  // ********************
  // Input synchronisers
  // ********************
  // Controller data must hold steady while its request is high
  logic [32:0] buc_s1_reg;
  logic [32:0] buc_s2_reg;
  logic early_power_off_warning_s1_reg;
  logic early_power_off_warning_s2_reg;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      buc_s1_reg <= 33'h0;
      buc_s2_reg <= 33'h0;
      early_power_off_warning_s1_reg <= 1'b0;
      early_power_off_warning_s2_reg <= 1'b0;
    end else begin
      buc_s1_reg <= {buc_req, buc_prio, buc_impl, buc_unit, buc_num};
      buc_s2_reg <= buc_s1_reg;
      early_power_off_warning_s1_reg <= early_power_off_warning_req;
      early_power_off_warning_s2_reg <= early_power_off_warning_s1_reg;
    end
  end
  // ********************
  // Registers
  // ********************
  ipp_prio_t cpp_reg;
  ipp_prio_t cpp_next;
  ipp_src_t src_reg;
  ipp_prio_t pres_prio_reg;
  logic [1:0] pres_idx_reg;
  ipp_prio_t ipi_prio_reg;
  ipp_prio_t gq_prio_reg;
  ipp_src_t gq_spec_reg;
  ipp_src_t buc_held_reg;
  logic [`IPP_NUM_SRC-1:0] hold_reg;
  // ********************
  // Access decode
  // ********************
  // Requests are taken only while no answer is being given
  logic take;
  logic rd_accept;
  logic st_cpp;
  logic st_eoi;
  logic st_ipi;
  logic st_gq;
  logic presented;
  logic reject;
  logic present;
  assign take = cpu_req && !cpu_ack;
  assign rd_accept = take && !cpu_write && !cpu_gsel && cpu_size4 && cpu_addr == `IPP_OFF_ACCEPT;
  assign st_cpp = take && cpu_write && !cpu_gsel && cpu_addr == `IPP_OFF_ACCEPT;
  assign st_eoi = st_cpp && cpu_size4;
  assign st_ipi = take && cpu_write && !cpu_gsel && cpu_addr == `IPP_OFF_IPI;
  assign st_gq = take && cpu_write && cpu_gsel && cpu_addr == `IPP_OFF_POLL;
  assign presented = src_reg != `IPP_SRC_NONE;
  assign cpp_next = cpu_wdata[`IPP_PRIO_MSB:`IPP_PRIO_LSB];
  // A store that makes the priority equal or better than the shown one removes it
  assign reject = st_cpp && presented && pres_prio_reg >= cpp_next;
  // ********************
  // Candidate sources
  // ********************
  logic [`IPP_NUM_SRC-1:0] cand_valid;
  logic [`IPP_NUM_SRC*8-1:0] cand_prio;
  ipp_src_t cand_src [`IPP_NUM_SRC];
  logic [`IPP_NUM_SRC-1:0] eoi_hit;
  logic best_valid;
  logic [1:0] best_idx;
  ipp_prio_t best_prio;
  always_comb begin
    cand_src[IPP_K_EARLY_POWER_OFF_WARNING] = `IPP_SRC_EARLY_POWER_OFF_WARNING;
    cand_src[IPP_K_IPI] = `IPP_SRC_OWN_IPI;
    cand_src[IPP_K_GLOBAL] = gq_spec_reg;
    cand_src[IPP_K_BUC] = buc_s2_reg[23:0];
    cand_prio = {buc_s2_reg[31:24], gq_prio_reg, ipi_prio_reg, EARLY_POWER_OFF_WARNING_PRIO};
    cand_valid[IPP_K_EARLY_POWER_OFF_WARNING] = early_power_off_warning_s2_reg;
    cand_valid[IPP_K_IPI] = ipi_prio_reg != `IPP_PRIO_LEAST;
    // A zero source would read as nothing pending, so it is never shown
    cand_valid[IPP_K_GLOBAL] = gq_prio_reg != `IPP_PRIO_LEAST && gq_spec_reg != `IPP_SRC_NONE;
    cand_valid[IPP_K_BUC] = buc_s2_reg[32] && buc_s2_reg[23:0] != `IPP_SRC_NONE;
  end
  genvar gi;
  generate
    for (gi = 0; gi < `IPP_NUM_SRC; gi++) begin : g_eoi
      if (gi == IPP_K_BUC) begin : g_held
        assign eoi_hit[gi] = cpu_wdata[`IPP_SRC_MSB:0] == buc_held_reg;
      end else begin : g_fixed
        assign eoi_hit[gi] = cpu_wdata[`IPP_SRC_MSB:0] == cand_src[gi];
      end
    end
  endgenerate
  ipp_prio_pick #(
    .N(`IPP_NUM_SRC)
  ) u_pick (
    .cand_valid(cand_valid & ~hold_reg),
    .cand_prio(cand_prio),
    .best_valid(best_valid),
    .best_idx(best_idx),
    .best_prio(best_prio)
  );
  // Nothing new is shown in the cycle an access is taken, which keeps accesses atomic
  assign present = !presented && !take && best_valid && best_prio < cpp_reg;
  // ********************
  // Processor answer
  // ********************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cpu_ack <= 1'b0;
      cpu_rdata <= 32'h0;
    end else begin
      cpu_ack <= take;
      if (take && !cpu_write) begin
        if (cpu_gsel) begin
          cpu_rdata <= (cpu_addr == `IPP_OFF_POLL) ? {gq_prio_reg, gq_spec_reg} : 32'h0;
        end else if (cpu_addr == `IPP_OFF_POLL || cpu_addr == `IPP_OFF_ACCEPT) begin
          // Byte reads return priority alone and never touch state
          cpu_rdata <= cpu_size4 ? {cpp_reg, src_reg} : {24'h0, cpp_reg};
        end else if (cpu_addr == `IPP_OFF_IPI) begin
          cpu_rdata <= {24'h0, ipi_prio_reg};
        end else begin
          cpu_rdata <= 32'h0;
        end
      end
    end
  end
  // ********************
  // Current priority
  // ********************
  // Firmware must write it before enabling; reset gives least favoured
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cpp_reg <= `IPP_PRIO_RESET;
    end else if (st_cpp) begin
      cpp_reg <= cpp_next;
    end else if (rd_accept && presented) begin
      cpp_reg <= pres_prio_reg;
    end
  end
  // ********************
  // Source field and request line
  // ********************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      src_reg <= `IPP_SRC_NONE;
      pres_prio_reg <= `IPP_PRIO_LEAST;
      pres_idx_reg <= 2'h0;
      cpu_irq <= 1'b0;
    end else if (reject || rd_accept) begin
      // Cleared together with the priority store or after the read data
      src_reg <= `IPP_SRC_NONE;
      cpu_irq <= 1'b0;
    end else if (present) begin
      src_reg <= cand_src[best_idx];
      pres_prio_reg <= best_prio;
      pres_idx_reg <= best_idx;
      cpu_irq <= 1'b1;
    end
  end
  // ********************
  // Source holds
  // ********************
  // A shown source waits for rejection or end of interrupt before it may return
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hold_reg <= '0;
      buc_held_reg <= `IPP_SRC_NONE;
    end else begin
      for (int i = 0; i < `IPP_NUM_SRC; i++) begin
        if (present && best_idx == 2'(i)) begin
          hold_reg[i] <= 1'b1;
        end else if ((reject && pres_idx_reg == 2'(i)) || (st_eoi && eoi_hit[i])) begin
          hold_reg[i] <= 1'b0;
        end
      end
      if (present && best_idx == IPP_K_BUC) begin
        buc_held_reg <= cand_src[IPP_K_BUC];
      end
    end
  end
  // ********************
  // Inter-processor and global queue words
  // ********************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ipi_prio_reg <= `IPP_PRIO_LEAST;
      gq_prio_reg <= `IPP_PRIO_LEAST;
      gq_spec_reg <= `IPP_SRC_NONE;
    end else begin
      if (st_ipi) begin
        ipi_prio_reg <= cpu_size4 ? cpu_wdata[`IPP_PRIO_MSB:`IPP_PRIO_LSB] : cpu_wdata[7:0];
      end
      if (st_gq) begin
        gq_prio_reg <= cpu_size4 ? cpu_wdata[`IPP_PRIO_MSB:`IPP_PRIO_LSB] : cpu_wdata[7:0];
        if (cpu_size4) begin
          gq_spec_reg <= cpu_wdata[`IPP_SRC_MSB:0];
        end
      end
    end
  end
  // ********************
  // Source notifications
  // ********************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      eoi_valid <= 1'b0;
      eoi_source <= `IPP_SRC_NONE;
      buc_taken <= 1'b0;
      buc_reject <= 1'b0;
    end else begin
      eoi_valid <= st_eoi;
      if (st_eoi) begin
        eoi_source <= cpu_wdata[`IPP_SRC_MSB:0];
      end
      buc_taken <= rd_accept && presented && pres_idx_reg == IPP_K_BUC;
      buc_reject <= reject && pres_idx_reg == IPP_K_BUC;
    end
  end
  // ********************
  // Checks
  // ********************
  accept_clears_src_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    rd_accept |=> src_reg == `IPP_SRC_NONE && !cpu_irq)
    else $error("source not cleared after accepting read");
  accept_rdata_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    rd_accept |=> cpu_ack && cpu_rdata == {$past(cpp_reg), $past(src_reg)})
    else $error("accepting read returned wrong word");
  poll_no_change_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    (take && !cpu_write && cpu_addr == `IPP_OFF_POLL && !cpu_gsel) |=> $stable(src_reg) && $stable(cpp_reg))
    else $error("polling read changed state");
  byte_read_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    (take && !cpu_write && !cpu_size4 && !cpu_gsel && cpu_addr == `IPP_OFF_ACCEPT) |=>
    cpu_rdata == {24'h0, $past(cpp_reg)} && $stable(src_reg))
    else $error("byte priority read wrong or had side effect");
  accept_loads_cpp_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    (rd_accept && presented) |=> cpp_reg == $past(pres_prio_reg))
    else $error("priority not loaded on accept");
  filter_prio_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(cpu_irq) |-> pres_prio_reg < cpp_reg && src_reg != `IPP_SRC_NONE)
    else $error("request shown that is not more favoured");
  reject_drop_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    reject |=> !cpu_irq && src_reg == `IPP_SRC_NONE && cpp_reg == $past(cpp_next))
    else $error("rejection did not clear source and line");
  eoi_source_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    st_eoi |=> eoi_valid && eoi_source == $past(cpu_wdata[23:0]))
    else $error("end of interrupt sent to wrong source");
  ipi_empty_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    (present && best_idx == IPP_K_IPI) |-> ipi_prio_reg != `IPP_PRIO_LEAST)
    else $error("empty request register signalled");
  line_matches_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    cpu_irq |-> src_reg != `IPP_SRC_NONE)
    else $error("line high with no source");
  // ********************
  // Access and presentation checks
  // ********************
  ack_one_cycle_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    take |=> cpu_ack ##1 !cpu_ack)
    else $error("acknowledge not a single cycle");
  store_cpp_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    st_cpp |=> cpp_reg == $past(cpp_next))
    else $error("priority store not written");
  byte_store_no_eoi_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_cpp && !cpu_size4) |=> !eoi_valid)
    else $error("byte priority store ended an interrupt");
  present_load_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    present |=> cpu_irq && pres_prio_reg == $past(best_prio) && pres_prio_reg < cpp_reg)
    else $error("shown request has wrong priority");
  line_favoured_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    cpu_irq |-> pres_prio_reg < cpp_reg)
    else $error("line high for a request not more favoured");
  src_early_power_off_warning_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    (present && best_idx == IPP_K_EARLY_POWER_OFF_WARNING) |=> src_reg == `IPP_SRC_EARLY_POWER_OFF_WARNING)
    else $error("power warning source value wrong");
  src_ipi_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    (present && best_idx == IPP_K_IPI) |=> src_reg == `IPP_SRC_OWN_IPI)
    else $error("own request register source value wrong");
  src_global_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    (present && best_idx == IPP_K_GLOBAL) |=> src_reg == $past(gq_spec_reg))
    else $error("global queue source value wrong");
  src_buc_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    (present && best_idx == IPP_K_BUC) |=> src_reg == $past(buc_s2_reg[23:0]))
    else $error("controller source value wrong");
  taken_pulse_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    (rd_accept && presented && pres_idx_reg == IPP_K_BUC) |=> buc_taken)
    else $error("controller not told of acceptance");
  reject_notice_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    (reject && pres_idx_reg == IPP_K_BUC) |=> buc_reject)
    else $error("controller not told of rejection");
  keep_less_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_cpp && presented && cpp_next > pres_prio_reg) |=> cpu_irq && $stable(src_reg))
    else $error("less favoured priority store dropped request");
  poll_store_ignored_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    (take && cpu_write && !cpu_gsel && cpu_addr == `IPP_OFF_POLL) |=> $stable(cpp_reg) && $stable(src_reg))
    else $error("store at poll offset changed state");
  gq_word_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_gq && cpu_size4) |=>
    gq_prio_reg == $past(cpu_wdata[31:24]) && gq_spec_reg == $past(cpu_wdata[23:0]))
    else $error("global queue word not written");
  poll_line_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    (take && !cpu_write && !cpu_gsel && cpu_addr == `IPP_OFF_POLL) |=> $stable(cpu_irq))
    else $error("polling read moved the line");
  eoi_pulse_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    eoi_valid |=> !eoi_valid)
    else $error("end of interrupt longer than one cycle");
  accept_empty_cpp_a : assert property (@(posedge ref_clk) disable iff (!resetn)
    (rd_accept && !presented) |=> $stable(cpp_reg))
    else $error("empty accept changed priority");
endmodule : ipp_present
`default_nettype wire

/* testbench/ipp_cpu_model.sv */
// Processor core model issuing loads and stores to the presentation block
`timescale 1ns/1ps
`default_nettype none
module ipp_cpu_model (
  // Clock
  input wire logic ref_clk,
  // Load and store port
  output logic cpu_req,
  output logic cpu_write,
  output logic cpu_gsel,
  output logic cpu_size4,
  output logic [3:0] cpu_addr,
  output logic [31:0] cpu_wdata,
  input wire logic [31:0] cpu_rdata,
  input wire logic cpu_ack
);
  // ********************
  // Bus cycle
  // ********************
  // Lost acknowledges are counted so the bench can fail on them
  int n_ack_lost = 0;
  initial begin
    {cpu_req, cpu_write, cpu_gsel, cpu_size4} = 4'h0;
    cpu_addr = 4'h0;
    cpu_wdata = 32'h0;
  end
  task automatic access(input logic wr, input logic gs, input logic s4, input logic [3:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge ref_clk);
    {cpu_req, cpu_write, cpu_gsel, cpu_size4} <= {1'b1, wr, gs, s4};
    cpu_addr <= a;
    cpu_wdata <= wd;
    n = 0;
    // Held until acknowledge is sampled; requests during it are ignored anyway
    do begin
      @(posedge ref_clk);
      n++;
    end while (cpu_ack !== 1'b1 && n < 16);
    if (cpu_ack !== 1'b1) begin
      n_ack_lost++;
    end
    rd = cpu_rdata;
    // Released lines show the inverse so a stale value cannot pass for a live one
    cpu_req <= 1'b0;
    cpu_addr <= ~a;
    cpu_wdata <= ~wd;
  endtask : access
endmodule : ipp_cpu_model
`default_nettype wire

/* testbench/ipp_present_tb.sv */
// Self-checking bench for the interrupt presentation block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module ipp_present_tb import ipp_pkg::*;;
  typedef struct {ipp_prio_t cpp; ipp_prio_t prio; logic shown;} ipp_row_s;
  logic ref_clk, resetn, cpu_req, cpu_write, cpu_gsel, cpu_size4, cpu_ack, cpu_irq;
  logic [3:0] cpu_addr;
  logic [31:0] cpu_wdata, cpu_rdata, rd;
  logic buc_req, early_power_off_warning_req, buc_taken, buc_reject, eoi_valid;
  logic [7:0] buc_prio;
  logic [10:0] buc_impl;
  logic [8:0] buc_unit;
  logic [3:0] buc_num;
  logic [23:0] eoi_source, src_exp;
  int n_mismatch, check_count;
  ipp_row_s rows [4] = '{'{8'h80, 8'h40, 1'b1}, '{8'h40, 8'h40, 1'b0}, '{8'h40, 8'h41, 1'b0},
                         '{8'hFF, 8'hFE, 1'b1}};
  ipp_present ipp_present_i (.ref_clk, .resetn, .cpu_req, .cpu_write, .cpu_gsel, .cpu_size4,
    .cpu_addr, .cpu_wdata, .cpu_rdata, .cpu_ack, .cpu_irq, .buc_req, .buc_prio, .buc_impl,
    .buc_unit, .buc_num, .early_power_off_warning_req, .buc_taken, .buc_reject, .eoi_valid, .eoi_source);
  ipp_cpu_model ipp_cpu_model_i (.ref_clk, .cpu_req, .cpu_write, .cpu_gsel, .cpu_size4,
    .cpu_addr, .cpu_wdata, .cpu_rdata, .cpu_ack);
  assign src_exp = {buc_impl, buc_unit, buc_num};
  // ********************
  // Helpers
  // ********************
  task automatic st(input logic gs, input logic s4, input logic [3:0] a, input logic [31:0] wd);
    ipp_cpu_model_i.access(1'b1, gs, s4, a, wd, rd);
  endtask : st
  task automatic ld(input logic [3:0] a, input logic s4 = 1'b1);
    ipp_cpu_model_i.access(1'b0, 1'b0, s4, a, 32'h0, rd);
  endtask : ld
  // Byte data in both lanes, so each offset gets the value whichever lane it takes
  task automatic pr(input logic gs, input logic [3:0] a, input ipp_prio_t p);
    st(gs, 1'b0, a, {p, 16'h0000, p});
  endtask : pr
  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wait_n
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    #100000;
    n_mismatch++;
    final_report();
  end
  // ********************
  // Tests
  // ********************
  initial begin
    {resetn, buc_req, early_power_off_warning_req} = 3'h0;
    buc_prio = 8'h00;
    buc_impl = 11'h5A3;
    buc_unit = 9'h012;
    buc_num = 4'h7;
    n_mismatch = 0;
    check_count = 0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    ld(4'h0);
    `CHK(rd, 32'hFF000000)
    `CHK(cpu_irq, 1'b0)
    pr(1'b0, 4'h4, 8'hFF);
    pr(1'b0, 4'hC, 8'hFF);
    foreach (rows[i]) begin
      pr(1'b0, 4'h4, rows[i].cpp);
      @(posedge ref_clk);
      buc_prio <= rows[i].prio;
      buc_req <= 1'b1;
      wait_n(6);
      ld(4'h0);
      `CHK(rd, {rows[i].cpp, rows[i].shown ? src_exp : 24'h000000})
      `CHK(cpu_irq, rows[i].shown)
      ld(4'h4);
      `CHK(rd, {rows[i].cpp, rows[i].shown ? src_exp : 24'h000000})
      `CHK(buc_taken, rows[i].shown)
      @(posedge ref_clk);
      buc_req <= 1'b0;
      ld(4'h0);
      `CHK(rd, {rows[i].shown ? rows[i].prio : rows[i].cpp, 24'h000000})
      st(1'b0, 1'b1, 4'h4, {8'hFF, src_exp});
      `CHK(eoi_source, src_exp)
      `CHK(eoi_valid, 1'b1)
    end
    // Store of a priority equal to the shown one must take it away
    pr(1'b0, 4'h4, 8'h80);
    @(posedge ref_clk);
    buc_prio <= 8'h40;
    buc_req <= 1'b1;
    wait_n(6);
    pr(1'b0, 4'h4, 8'hA0);
    `CHK(cpu_irq, 1'b1)
    pr(1'b0, 4'h4, 8'h40);
    `CHK(buc_reject, 1'b1)
    `CHK(cpu_irq, 1'b0)
    ld(4'h0);
    `CHK(rd, 32'h40000000)
    @(posedge ref_clk);
    buc_req <= 1'b0;
    wait_n(3);
    pr(1'b0, 4'h4, 8'hFF);
    pr(1'b0, 4'hC, 8'h30);
    wait_n(3);
    ld(4'h4);
    `CHK(rd, 32'hFF000002)
    ld(4'h0);
    `CHK(rd, 32'h30000000)
    st(1'b0, 1'b1, 4'hC, 32'hFF000000);
    st(1'b0, 1'b1, 4'h4, 32'hFF000002);
    wait_n(3);
    ld(4'h0);
    `CHK(rd, 32'hFF000000)
    @(posedge ref_clk);
    early_power_off_warning_req <= 1'b1;
    wait_n(6);
    ld(4'h4);
    `CHK(rd, 32'hFF000001)
    @(posedge ref_clk);
    early_power_off_warning_req <= 1'b0;
    wait_n(3);
    ld(4'h0);
    `CHK(rd, 32'h00000000)
    st(1'b0, 1'b1, 4'h4, 32'hFF000001);
    `CHK(eoi_source, 24'h000001)
    st(1'b1, 1'b1, 4'h0, 32'h50000110);
    ipp_cpu_model_i.access(1'b0, 1'b1, 1'b1, 4'h0, 32'h0, rd);
    `CHK(rd, 32'h50000110)
    wait_n(3);
    ld(4'h0);
    `CHK(rd, 32'hFF000110)
    ld(4'h4, 1'b0);
    `CHK(rd, 32'h000000FF)
    `CHK(cpu_irq, 1'b1)
    pr(1'b1, 4'h0, 8'hFF);
    ld(4'h4);
    `CHK(rd, 32'hFF000110)
    st(1'b0, 1'b1, 4'h4, 32'hFF000110);
    // Store at the poll offset and an unmapped load change nothing
    st(1'b0, 1'b1, 4'h0, 32'h12345678);
    ld(4'h0);
    `CHK(rd, 32'hFF000000)
    ld(4'h8);
    `CHK(rd, 32'h00000000)
    ld(4'h0, 1'b0);
    `CHK(rd, 32'h000000FF)
    // Reset in mid-run while a warning is shown
    @(posedge ref_clk);
    early_power_off_warning_req <= 1'b1;
    wait_n(6);
    `CHK(cpu_irq, 1'b1)
    resetn <= 1'b0;
    early_power_off_warning_req <= 1'b0;
    wait_n(2);
    `CHK(cpu_irq, 1'b0)
    resetn <= 1'b1;
    ld(4'h0);
    `CHK(rd, 32'hFF000000)
    ld(4'hC, 1'b0);
    `CHK(rd, 32'h000000FF)
    `CHK(ipp_cpu_model_i.n_ack_lost, 0)
    final_report();
  end
endmodule : ipp_present_tb
`default_nettype wire
